// ---- hdl/stbma_pkg.sv ----
// Operation
// - address and data tenures run independently
// - single-beat ack or last burst ack ends
// - master samples reads, drives writes on data
// - address-only transfer uses no data tenure
// - busy lines driven only while owning bus
// - request line asserted while address bus needed
// - take address bus only on qualified grant
// - parked qualified grant taken without request
// - address busy asserted throughout address mastership
// - data grant qualified by busy and retries
// - only associated address retry blocks data grant
// - write-only lets pending write pass reads
// - qualified data grant always taken when needed
// - at most one pipelined address tenure ahead
// - data tenures follow address order, except write-only
// - on grant: busy, drop request, address, start
package stbma_pkg;

    // ****************************************
    // widths and counts
    // ****************************************
    localparam int STBMA_ADDR_W = 32;
    localparam int STBMA_DATA_W = 64;
    localparam int STBMA_FIFO_DEPTH = 16;
    localparam int STBMA_BURST_BEATS = 4;
    localparam int STBMA_PEND_SLOTS = 2;

    // ****************************************
    // request word layout
    // ****************************************
    localparam int STBMA_REQ_W = STBMA_DATA_W + STBMA_ADDR_W + 3;
    localparam int STBMA_POS_DATA = 0;
    localparam int STBMA_POS_ADDR = STBMA_DATA_W;
    localparam int STBMA_POS_BURST = STBMA_DATA_W + STBMA_ADDR_W;
    localparam int STBMA_POS_WRITE = STBMA_POS_BURST + 1;
    localparam int STBMA_POS_AONLY = STBMA_POS_BURST + 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] STBMA_BEAT_RST = 3'h0;
    localparam logic STBMA_FLAG_RST = 1'b0;

    // ****************************************
    // tenure states
    // ****************************************
    typedef enum logic [1:0] {
        STBMA_A_IDLE,
        STBMA_A_XFER,
        STBMA_A_SNOOP
    } stbma_astate_e;

    typedef enum logic [0:0] {
        STBMA_D_IDLE,
        STBMA_D_XFER
    } stbma_dstate_e;

endpackage : stbma_pkg

// ---- hdl/stbma_fifo.sv ----
`timescale 1ns/1ns
module stbma_fifo
    import stbma_pkg::*;
#(
    parameter int WIDTH = STBMA_REQ_W,
    parameter int DEPTH = STBMA_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } stbma_fifo_s;

    stbma_fifo_s s_r;
    stbma_fifo_s s_nxt;
    logic do_wr;
    logic do_rd;

    // ****************************************
    // handshakes
    // ****************************************
    // full and empty come straight from the count, so back-pressure is exact
    assign in_ready_o = (s_r.cnt != CNT_FULL);
    assign out_valid_o = (s_r.cnt != '0);
    assign out_data_o = s_r.mem[s_r.rp];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    // next state: pointers wrap explicitly so depth need not be a power of two
    always_comb begin
        s_nxt = s_r;
        if (do_wr) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = (s_r.wp == PTR_LAST) ? '0 : s_r.wp + 1'b1;
        end
        if (do_rd) begin
            s_nxt.rp = (s_r.rp == PTR_LAST) ? '0 : s_r.rp + 1'b1;
        end
        if (do_wr && !do_rd) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : stbma_fifo

// ---- hdl/stbma_master.sv ----
`timescale 1ns/1ns
module stbma_master
    import stbma_pkg::*;
#(
    parameter int FIFO_DEPTH = STBMA_FIFO_DEPTH,
    parameter int BURST_BEATS = STBMA_BURST_BEATS
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // user request stream
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [STBMA_ADDR_W-1:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_burst_i,
    input wire logic req_addr_only_i,
    input wire logic [STBMA_DATA_W-1:0] req_wdata_i,
    // user read return
    output logic rd_valid_o,
    output logic rd_last_o,
    output logic [STBMA_DATA_W-1:0] rd_data_o,
    // address bus arbitration
    output logic addr_bus_request_o,
    input wire logic addr_bus_grant_i,
    input wire logic addr_busy_i,
    output logic addr_busy_o,
    output logic addr_busy_oe_o,
    input wire logic addr_retry_i,
    input wire logic addr_ack_i,
    // address transfer
    output logic xfer_start_o,
    output logic addr_oe_o,
    output logic [STBMA_ADDR_W-1:0] addr_o,
    output logic xfer_write_o,
    output logic xfer_burst_o,
    output logic xfer_addr_only_o,
    // data bus arbitration
    input wire logic data_bus_grant_i,
    input wire logic data_busy_i,
    output logic data_busy_o,
    output logic data_busy_oe_o,
    input wire logic data_retry_i,
    input wire logic write_only_i,
    // data transfer
    input wire logic data_ack_i,
    input wire logic [STBMA_DATA_W-1:0] data_i,
    output logic [STBMA_DATA_W-1:0] data_o,
    output logic data_oe_o
);

    localparam logic [2:0] BEAT_LAST = 3'(BURST_BEATS - 1);

    typedef struct packed {
        stbma_astate_e a_st;
        stbma_dstate_e d_st;
        logic [STBMA_PEND_SLOTS-1:0] slot_v;
        logic [STBMA_PEND_SLOTS-1:0] slot_w;
        logic [STBMA_PEND_SLOTS-1:0] slot_b;
        logic [STBMA_PEND_SLOTS-1:0] slot_c;
        logic [STBMA_PEND_SLOTS-1:0][STBMA_DATA_W-1:0] slot_d;
        logic d_sel;
        logic [2:0] beat;
        logic ts;
        logic [STBMA_ADDR_W-1:0] addr;
        logic xw;
        logic xb;
        logic xao;
        logic [STBMA_DATA_W-1:0] dout;
        logic ddrv;
        logic [STBMA_DATA_W-1:0] rdat;
        logic rval;
        logic rlast;
    } stbma_state_s;

    stbma_state_s s_r;
    stbma_state_s s_nxt;

    // ****************************************
    // request queue
    // ****************************************
    logic hd_valid;
    logic fifo_pop;
    logic [STBMA_REQ_W-1:0] hd_word;
    logic hd_ao;
    logic hd_w;
    logic hd_b;
    logic [STBMA_ADDR_W-1:0] hd_a;
    logic [STBMA_DATA_W-1:0] hd_d;

    // the head stays queued until the snoop window passes, so a retry replays it
    stbma_fifo #(
        .WIDTH(STBMA_REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(req_valid_i),
        .in_ready_o(req_ready_o),
        .in_data_i({req_addr_only_i, req_write_i, req_burst_i, req_addr_i, req_wdata_i}),
        .out_valid_o(hd_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(hd_word)
    );

    assign hd_ao = hd_word[STBMA_POS_AONLY];
    assign hd_w = hd_word[STBMA_POS_WRITE];
    assign hd_b = hd_word[STBMA_POS_BURST];
    assign hd_a = hd_word[STBMA_POS_ADDR +: STBMA_ADDR_W];
    assign hd_d = hd_word[STBMA_POS_DATA +: STBMA_DATA_W];

    // ****************************************
    // qualification
    // ****************************************
    logic need_bus;
    logic qual_ag;
    logic qual_dg;
    logic dsel;

    // a new data-carrying address tenure only when a pending slot is free, one level deep; address-only ones need no slot
    assign need_bus = hd_valid && (hd_ao || !s_r.slot_v[1]);
    assign qual_ag = addr_bus_grant_i && !addr_busy_i && !addr_retry_i;

    // write-only lets a queued write overtake an older read
    assign dsel = write_only_i && s_r.slot_v[1] && s_r.slot_w[1] && !s_r.slot_w[0];

    // retry blocks the grant only for the tenure still in its snoop window
    assign qual_dg = data_bus_grant_i && !data_busy_i && !data_retry_i
                     && !(addr_retry_i && !s_r.slot_c[dsel]);

    // ****************************************
    // outputs
    // ****************************************
    // parked: a grant already present means no request is raised
    assign addr_bus_request_o = (s_r.a_st == STBMA_A_IDLE) && need_bus && !addr_bus_grant_i;
    assign addr_busy_o = (s_r.a_st == STBMA_A_XFER);
    assign addr_busy_oe_o = (s_r.a_st == STBMA_A_XFER);
    assign addr_oe_o = (s_r.a_st == STBMA_A_XFER);
    assign xfer_start_o = s_r.ts;
    assign addr_o = s_r.addr;
    assign xfer_write_o = s_r.xw;
    assign xfer_burst_o = s_r.xb;
    assign xfer_addr_only_o = s_r.xao;
    assign data_busy_o = (s_r.d_st == STBMA_D_XFER);
    assign data_busy_oe_o = (s_r.d_st == STBMA_D_XFER);
    assign data_o = s_r.dout;
    assign data_oe_o = s_r.ddrv;
    assign rd_valid_o = s_r.rval;
    assign rd_last_o = s_r.rlast;
    assign rd_data_o = s_r.rdat;

    // last beat of the running tenure
    function automatic logic stbma_is_last(input logic burst, input logic [2:0] beat);
        stbma_is_last = !burst || (beat == BEAT_LAST);
    endfunction : stbma_is_last

    // ****************************************
    // next state
    // ****************************************
    logic [STBMA_PEND_SLOTS-1:0] kill;
    logic enq;
    logic conf;
    logic eidx;

    always_comb begin
        s_nxt = s_r;
        kill = '0;
        enq = 1'b0;
        conf = 1'b0;
        eidx = 1'b0;
        fifo_pop = 1'b0;
        s_nxt.ts = 1'b0;
        s_nxt.rval = 1'b0;
        s_nxt.rlast = 1'b0;
        // address tenure
        case (s_r.a_st)
            STBMA_A_IDLE: begin
                if (need_bus && qual_ag) begin
                    s_nxt.a_st = STBMA_A_XFER;
                    s_nxt.ts = 1'b1;
                    s_nxt.addr = hd_a;
                    s_nxt.xw = hd_w;
                    s_nxt.xb = hd_b;
                    s_nxt.xao = hd_ao;
                    enq = !hd_ao;
                end
            end
            STBMA_A_XFER: begin
                if (addr_ack_i) begin
                    s_nxt.a_st = STBMA_A_SNOOP;
                end
            end
            STBMA_A_SNOOP: begin
                // busy stays low here, giving the gap after acknowledge
                s_nxt.a_st = STBMA_A_IDLE;
                if (addr_retry_i) begin
                    kill = s_r.slot_v & ~s_r.slot_c;
                end else begin
                    fifo_pop = 1'b1;
                    conf = 1'b1;
                end
            end
            default: begin
                s_nxt.a_st = STBMA_A_IDLE;
            end
        endcase
        // data tenure, may start while the address tenure still runs
        case (s_r.d_st)
            STBMA_D_IDLE: begin
                if (s_r.slot_v[dsel] && qual_dg) begin
                    s_nxt.d_st = STBMA_D_XFER;
                    s_nxt.d_sel = dsel;
                    s_nxt.beat = STBMA_BEAT_RST;
                    s_nxt.dout = s_r.slot_d[dsel];
                    s_nxt.ddrv = s_r.slot_w[dsel];
                end
            end
            STBMA_D_XFER: begin
                if (kill[s_r.d_sel]) begin
                    // the address tenure behind it was retried: drop the data
                    s_nxt.d_st = STBMA_D_IDLE;
                    s_nxt.ddrv = STBMA_FLAG_RST;
                end else if (data_ack_i) begin
                    s_nxt.beat = s_r.beat + 3'h1;
                    if (!s_r.slot_w[s_r.d_sel]) begin
                        s_nxt.rdat = data_i;
                        s_nxt.rval = 1'b1;
                    end
                    if (stbma_is_last(s_r.slot_b[s_r.d_sel], s_r.beat)) begin
                        kill[s_r.d_sel] = 1'b1;
                        s_nxt.d_st = STBMA_D_IDLE;
                        s_nxt.ddrv = STBMA_FLAG_RST;
                        s_nxt.rlast = !s_r.slot_w[s_r.d_sel];
                    end
                end
            end
            default: begin
                s_nxt.d_st = STBMA_D_IDLE;
            end
        endcase
        // compact the pending slots so slot 0 is always the oldest
        if (kill == 2'h3) begin
            s_nxt.slot_v = '0;
        end else if (kill[0]) begin
            s_nxt.slot_v[0] = s_r.slot_v[1];
            s_nxt.slot_w[0] = s_r.slot_w[1];
            s_nxt.slot_b[0] = s_r.slot_b[1];
            s_nxt.slot_c[0] = s_r.slot_c[1];
            s_nxt.slot_d[0] = s_r.slot_d[1];
            s_nxt.slot_v[1] = 1'b0;
        end else if (kill[1]) begin
            s_nxt.slot_v[1] = 1'b0;
        end
        if (conf) begin
            s_nxt.slot_c = s_nxt.slot_v;
        end
        if (enq) begin
            eidx = s_nxt.slot_v[0];
            s_nxt.slot_v[eidx] = 1'b1;
            s_nxt.slot_w[eidx] = hd_w;
            s_nxt.slot_b[eidx] = hd_b;
            s_nxt.slot_c[eidx] = 1'b0;
            s_nxt.slot_d[eidx] = hd_d;
        end
    end

    // state register; all flags clear and both buses released at reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_grant_taken: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.a_st == STBMA_A_IDLE && need_bus && qual_ag) |=> xfer_start_o && addr_busy_oe_o)
        else $error("qualified grant not taken");
    a_grant_unqual: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.a_st == STBMA_A_IDLE && (!addr_bus_grant_i || addr_busy_i || addr_retry_i)) |=> !xfer_start_o)
        else $error("address bus taken without qualified grant");
    a_take_sequence: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        xfer_start_o |-> addr_busy_o && addr_oe_o && !addr_bus_request_o && addr_o == $past(hd_a))
        else $error("start without busy, address or dropped request");
    a_busy_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (xfer_start_o && !addr_ack_i) |=> addr_busy_o)
        else $error("address busy dropped before acknowledge");
    a_busy_gap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (addr_busy_oe_o && addr_ack_i) |=> !addr_busy_oe_o [*2])
        else $error("address busy not negated after acknowledge");
    a_depth_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.a_st == STBMA_A_IDLE && s_r.slot_v[1] && !hd_ao) |=> !xfer_start_o)
        else $error("second pipelined address tenure started");
    a_data_take: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.d_st == STBMA_D_IDLE && s_r.slot_v[dsel] && qual_dg) |=> data_busy_oe_o && data_oe_o == s_r.slot_w[s_r.d_sel])
        else $error("qualified data grant not taken");
    a_data_unqual: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.d_st == STBMA_D_IDLE && (data_busy_i || data_retry_i || !data_bus_grant_i)) |=> !data_busy_oe_o)
        else $error("data bus taken without qualified grant");
    a_single_end: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (data_busy_oe_o && data_ack_i && !s_r.slot_b[s_r.d_sel]) |=> !data_busy_oe_o && !data_oe_o)
        else $error("single beat did not end data tenure");
    a_burst_mid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (data_busy_oe_o && data_ack_i && s_r.slot_b[s_r.d_sel] && s_r.beat == 3'h0 && !kill[s_r.d_sel])
        |=> data_busy_oe_o)
        else $error("burst ended on first beat");
    a_write_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.d_st == STBMA_D_IDLE && qual_dg && write_only_i && s_r.slot_v == 2'h3 && !s_r.slot_w[0] && s_r.slot_w[1])
        |=> s_r.d_sel && data_oe_o)
        else $error("write-only did not pass pending write");
    a_reset_idle: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> !addr_busy_oe_o && !data_busy_oe_o && !addr_bus_request_o && !data_oe_o)
        else $error("bus driven after reset");

    c_parked: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.a_st == STBMA_A_IDLE && need_bus && qual_ag && !$past(addr_bus_request_o)));
    c_retry: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.a_st == STBMA_A_SNOOP && addr_retry_i));
    c_reorder: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_r.d_st == STBMA_D_IDLE && qual_dg && dsel));
    c_burst_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (data_busy_oe_o && data_ack_i && s_r.slot_b[s_r.d_sel] && s_r.beat == BEAT_LAST));

endmodule : stbma_master

// ---- dv/stbma_arb_model.sv ----
`timescale 1ns/1ns
// ****************************************
// far side: central arbiter, slave and snoop logic
// ****************************************
module stbma_arb_model
    import stbma_pkg::*;
#(
    parameter int RETRY_AT = 20
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // scenario knobs
    input wire logic park_i,
    input wire logic slow_i,
    input wire logic foreign_i,
    input wire logic wo_i,
    // master outputs watched
    input wire logic m_request_i,
    input wire logic m_abusy_i,
    input wire logic m_start_i,
    input wire logic [STBMA_ADDR_W-1:0] m_addr_i,
    input wire logic m_write_i,
    input wire logic m_burst_i,
    input wire logic m_aonly_i,
    input wire logic m_dbusy_i,
    input wire logic m_doe_i,
    // answers to the master
    output logic grant_o,
    output logic abusy_o,
    output logic aretry_o,
    output logic aack_o,
    output logic dgrant_o,
    output logic dbusy_o,
    output logic dretry_o,
    output logic wo_o,
    output logic dack_o,
    output logic [STBMA_DATA_W-1:0] data_o
);
    typedef struct packed {logic b; logic w; logic [STBMA_ADDR_W-1:0] a;} stbma_ent_s;
    stbma_ent_s q[$];
    stbma_ent_s ent_r;
    int starts = 0, sel, sel_r = 0, qn = 0;
    logic grant_r = 1'b0, snoop_r = 1'b0, hit_r = 1'b0, hold_r = 1'b0, dtog_r = 1'b0;
    logic push_r = 1'b0, pop_r = 1'b0, del_r = 1'b0;
    logic [1:0] await_r = 2'h0;
    logic [2:0] beat_r = 3'h0, lag_r = 3'h0;
    logic [STBMA_DATA_W-1:0] noise_r = '0;

    // one arbiter for both buses; a foreign master shows as busy and data retry
    assign grant_o = park_i | grant_r;
    assign abusy_o = foreign_i;
    assign dbusy_o = foreign_i;
    assign dretry_o = foreign_i;
    assign wo_o = wo_i;
    // early ack lets the next address tenure run ahead of data
    assign aack_o = m_abusy_i && (!slow_i || await_r[1]);
    assign aretry_o = snoop_r && hit_r;
    // data grant held back for a tenure that is about to be retried; with write-only on it also
    // waits up to seven cycles for a second tenure, so a write can queue behind a read
    assign dgrant_o = !(hold_r || (m_start_i && starts + 1 == RETRY_AT) || (wo_i && qn < 2 && lag_r != 3'h7));
    // every beat gets its own termination
    assign dack_o = m_dbusy_i && (!slow_i || dtog_r);

    // oldest tenure of the kind the master is moving
    always_comb begin
        sel = 0;
        for (int i = qn - 1; i >= 0; i--) begin
            if (q[i].w == m_doe_i) sel = i;
        end
        data_o = noise_r;
        if (dack_o && !m_doe_i && qn > 0) data_o = {q[sel].a ^ 32'h5A5A_0F0F, 29'h0, beat_r};
    end

    // released data lines show a walking pattern, not the last value
    always @(posedge clk_sys_i) begin
        noise_r <= {noise_r[STBMA_DATA_W-2:0], ~noise_r[STBMA_DATA_W-1]};
        grant_r <= m_request_i && !foreign_i;
        await_r <= m_abusy_i ? await_r + 2'h1 : 2'h0;
        dtog_r <= m_dbusy_i ? !dtog_r : 1'b0;
        snoop_r <= aack_o;
        lag_r <= m_start_i ? 3'h0 : lag_r + {2'h0, lag_r != 3'h7};
        // queue changes are only noted here and carried out at the falling edge
        push_r <= rst_n_i && m_start_i && !m_aonly_i;
        ent_r <= '{m_burst_i, m_write_i, m_addr_i};
        pop_r <= rst_n_i && aretry_o;
        del_r <= 1'b0;
        sel_r <= sel;
        if (!rst_n_i) begin
            starts <= 0;
            hit_r <= 1'b0;
            hold_r <= 1'b0;
            beat_r <= 3'h0;
        end else begin
            if (m_start_i) begin
                starts <= starts + 1;
                hit_r <= starts + 1 == RETRY_AT;
                hold_r <= starts + 1 == RETRY_AT;
            end
            if (aretry_o) begin
                hit_r <= 1'b0;
                hold_r <= 1'b0;
            end
            // only the last beat ends the tenure
            if (dack_o && qn > 0) begin
                beat_r <= beat_r + 3'h1;
                if (beat_r == (q[sel].b ? 3'(STBMA_BURST_BEATS - 1) : 3'h0)) begin
                    beat_r <= 3'h0;
                    del_r <= 1'b1;
                end
            end
        end
    end

    // blocking queue updates at the rising edge would race the master sampling data_i and grants
    always @(negedge clk_sys_i) begin
        if (!rst_n_i) q.delete();
        if (del_r) q.delete(sel_r);
        if (pop_r) void'(q.pop_back());
        if (push_r) q.push_back(ent_r);
        qn = q.size();
    end
endmodule : stbma_arb_model

// ---- dv/split_tenure_bus_master_arbitration_tb.sv ----
`timescale 1ns/1ns
module split_tenure_bus_master_arbitration_tb;
    import stbma_pkg::*;
    localparam int RETRY_AT = 20;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic req_valid_i = 1'b0, req_write_i = 1'b0, req_burst_i = 1'b0, req_addr_only_i = 1'b0;
    logic [STBMA_ADDR_W-1:0] req_addr_i = '0, addr_o;
    logic [STBMA_DATA_W-1:0] req_wdata_i = '0, rd_data_o, data_i, data_o;
    logic park = 1'b1, slow = 1'b0, foreign = 1'b0, wo = 1'b0;
    logic req_ready_o, rd_valid_o, rd_last_o, addr_bus_request_o, addr_bus_grant_i, addr_busy_i, addr_busy_o;
    logic addr_busy_oe_o, addr_retry_i, addr_ack_i, xfer_start_o, addr_oe_o, xfer_write_o, xfer_burst_o;
    logic xfer_addr_only_o, data_bus_grant_i, data_busy_i, data_busy_o, data_busy_oe_o, data_retry_i;
    logic write_only_i, data_ack_i, data_oe_o;
    int bad_count = 0, checks_done = 0, sent = 0, starts = 0;
    logic [STBMA_ADDR_W+2:0] exp_a[$];
    logic [STBMA_DATA_W:0] exp_rd[$];
    logic [STBMA_DATA_W-1:0] exp_wr[$];

    always #20 clk_sys_i = ~clk_sys_i;

    stbma_master dut (.clk_sys_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_write_i, .req_burst_i,
        .req_addr_only_i, .req_wdata_i, .rd_valid_o, .rd_last_o, .rd_data_o, .addr_bus_request_o,
        .addr_bus_grant_i, .addr_busy_i, .addr_busy_o, .addr_busy_oe_o, .addr_retry_i, .addr_ack_i,
        .xfer_start_o, .addr_oe_o, .addr_o, .xfer_write_o, .xfer_burst_o, .xfer_addr_only_o, .data_bus_grant_i,
        .data_busy_i, .data_busy_o, .data_busy_oe_o, .data_retry_i, .write_only_i, .data_ack_i, .data_i,
        .data_o, .data_oe_o);

    stbma_arb_model #(.RETRY_AT(RETRY_AT)) far (.clk_sys_i, .rst_n_i, .park_i(park), .slow_i(slow),
        .foreign_i(foreign), .wo_i(wo), .m_request_i(addr_bus_request_o), .m_abusy_i(addr_busy_o),
        .m_start_i(xfer_start_o), .m_addr_i(addr_o), .m_write_i(xfer_write_o), .m_burst_i(xfer_burst_o),
        .m_aonly_i(xfer_addr_only_o), .m_dbusy_i(data_busy_o), .m_doe_i(data_oe_o), .grant_o(addr_bus_grant_i),
        .abusy_o(addr_busy_i), .aretry_o(addr_retry_i), .aack_o(addr_ack_i), .dgrant_o(data_bus_grant_i),
        .dbusy_o(data_busy_i), .dretry_o(data_retry_i), .wo_o(write_only_i), .dack_o(data_ack_i),
        .data_o(data_i));

    task check(input string what, input logic [STBMA_DATA_W+STBMA_ADDR_W:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wrap_up;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // queue one request and note what the bus must show for it
    task send(input logic w, input logic b, input logic ao);
        logic [STBMA_ADDR_W-1:0] a;
        logic [STBMA_DATA_W-1:0] d;
        int n;
        a = $urandom & 32'hFFFF_FFF8;
        d = {$urandom, $urandom};
        sent++;
        if (sent == RETRY_AT) ao = 1'b0;
        // a retried address tenure shows up twice on the bus
        repeat (sent == RETRY_AT ? 2 : 1) exp_a.push_back({ao, w, b, a});
        for (int i = 0; i < (b ? STBMA_BURST_BEATS : 1); i++) begin
            if (ao) break;
            if (w) exp_wr.push_back(d);
            else exp_rd.push_back({i == (b ? STBMA_BURST_BEATS - 1 : 0), a ^ 32'h5A5A_0F0F, 29'h0, 3'(i)});
        end
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_addr_i <= a;
        req_write_i <= w;
        req_burst_i <= b;
        req_addr_only_i <= ao;
        req_wdata_i <= d;
        n = 0;
        @(negedge clk_sys_i);
        while (!req_ready_o) begin
            n++;
            if (n > 3000) begin
                bad_count++;
                wrap_up;
            end
            @(negedge clk_sys_i);
        end
    endtask : send

    task idle;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
    endtask : idle

    // bounded wait until every note has been matched
    task drain;
        int n;
        n = 0;
        while ((exp_a.size() + exp_rd.size() + exp_wr.size()) != 0 && n < 5000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("drained", {exp_a.size() != 0, exp_rd.size() != 0, exp_wr.size() != 0}, 3'h0);
        if (n >= 5000) wrap_up;
    endtask : drain

    // ****************************************
    // watcher: takes the oldest note for each result seen
    // ****************************************
    always @(posedge clk_sys_i) begin
        if (rst_n_i) begin
            if (xfer_start_o) begin
                starts++;
                check("address", {xfer_addr_only_o, xfer_write_o, xfer_burst_o, addr_o}, exp_a.pop_front());
                check("abusy", {addr_busy_o, addr_busy_oe_o, addr_oe_o, addr_bus_request_o}, 4'hE);
            end
            if (rd_valid_o) check("rdata", {rd_last_o, rd_data_o}, exp_rd.pop_front());
            if (data_ack_i && data_oe_o) check("wdata", {data_busy_oe_o, data_o}, {1'b1, exp_wr.pop_front()});
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h9bf4));
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        check("reset", {addr_bus_request_o, addr_busy_oe_o, data_busy_oe_o, xfer_start_o, data_oe_o}, 5'h0);
        // another master holds the bus: fill until the queue refuses
        @(posedge clk_sys_i);
        foreign <= 1'b1;
        repeat (STBMA_FIFO_DEPTH) send(1'($urandom), 1'($urandom), 1'b0);
        idle;
        @(negedge clk_sys_i);
        check("full", {req_ready_o, starts != 0}, 2'h0);
        @(posedge clk_sys_i);
        foreign <= 1'b0;
        drain;
        // unparked/parked, prompt/slow, write-only on and off
        for (int ph = 0; ph < 4; ph++) begin
            @(posedge clk_sys_i);
            park <= ph[0];
            slow <= ph[1];
            wo <= ph[0];
            repeat (8) send(1'($urandom), 1'($urandom), ($urandom % 5) == 0);
            idle;
            drain;
        end
        wrap_up;
    end
endmodule : split_tenure_bus_master_arbitration_tb
